// >>> logic/accr_regs.sv
// Purpose: Calibration and configuration registers for channels zero/one
// Assumes: Avalon-MM slave with waitrequest, byte address = index * 4
// Notes: Every access answers one cycle after it is presented
`timescale 1ns/10ps

module accr_regs (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [accr_pkg::ADDR_W+1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [accr_pkg::DATA_W-1:0] i_avs_writedata,
	output logic [accr_pkg::DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_avs_readdatavalid,
	output logic [23:0] o_chan0_gain,
	output logic [23:0] o_chan1_offset,
	output logic [15:0] o_chan1_gain_bits_high,
	output logic [9:0] o_chan1_phase_delay,
	output logic [1:0] o_chan1_input_select,
	output logic o_chan1_input_pair_connect,
	output logic o_chan1_inputs_shorted,
	output logic o_chan1_dc_diag,
	output logic o_chan1_ac_diag
);
	localparam int NREG = 6;
	localparam int R_G0H = 0;
	localparam int R_G0L = 1;
	localparam int R_CFG = 2;
	localparam int R_O1H = 3;
	localparam int R_O1L = 4;
	localparam int R_G1H = 5;
	localparam logic [NREG*16-1:0] RSTS = {
		accr_pkg::RST_CH1_GAIN_HI, accr_pkg::RST_CH1_OFFS_LO,
		accr_pkg::RST_CH1_OFFS_HI, accr_pkg::RST_CH1_CONFIG,
		accr_pkg::RST_CH0_GAIN_LO, accr_pkg::RST_CH0_GAIN_HI};
	localparam logic [NREG*16-1:0] MASKS = {
		accr_pkg::MASK_FULL, accr_pkg::MASK_LOW_BYTE,
		accr_pkg::MASK_FULL, accr_pkg::MASK_CONFIG,
		accr_pkg::MASK_LOW_BYTE, accr_pkg::MASK_FULL};

	logic [accr_pkg::ADDR_W-1:0] index;
	logic [NREG-1:0] hit;
	logic [15:0] value [NREG];
	logic busy_q;
	logic accept;
	logic [accr_pkg::DATA_W-1:0] rdata_d;
	logic [accr_pkg::DATA_W-1:0] rdata_q;
	logic rvalid_q;
	logic [23:0] gain0_q;
	logic [23:0] offs1_q;
	logic [15:0] gain1_q;
	logic [9:0] phase_q;
	logic [1:0] sel_q;

	// Word index; byte-lane bits of the address are ignored
	assign index = i_avs_address[accr_pkg::ADDR_W+1:2];

	// One wait cycle gives registered read data without a long path
	assign accept = (i_avs_read | i_avs_write) & busy_q;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			busy_q <= 1'b0;
		else if (accept)
			busy_q <= 1'b0;
		else if (i_avs_read | i_avs_write)
			busy_q <= 1'b1;
	end

	always_comb
	begin
		hit = '0;
		if (index == accr_pkg::IDX_CH0_GAIN_HI)
			hit[R_G0H] = 1'b1;
		else if (index == accr_pkg::IDX_CH0_GAIN_LO)
			hit[R_G0L] = 1'b1;
		else if (index == accr_pkg::IDX_CH1_CONFIG)
			hit[R_CFG] = 1'b1;
		else if (index == accr_pkg::IDX_CH1_OFFS_HI)
			hit[R_O1H] = 1'b1;
		else if (index == accr_pkg::IDX_CH1_OFFS_LO)
			hit[R_O1L] = 1'b1;
		else if (index == accr_pkg::IDX_CH1_GAIN_HI)
			hit[R_G1H] = 1'b1;
	end

	genvar g;
	generate
		for (g = 0; g < NREG; g++)
		begin : g_reg
			accr_field_reg #(
				.RESET_VAL(RSTS[g*16 +: 16]),
				.WMASK(MASKS[g*16 +: 16])
			) u_reg (
				.i_clk_sys(i_clk_sys),
				.i_rst(i_rst),
				.i_we(accept & i_avs_write & hit[g]),
				.i_be(i_avs_byteenable[1:0]),
				.i_wdata(i_avs_writedata[15:0]),
				.o_value(value[g])
			);
		end
	endgenerate

	// Unmapped indices read zero and swallow writes
	always_comb
	begin
		rdata_d = '0;
		for (int k = 0; k < NREG; k++)
		begin
			if (hit[k])
				rdata_d = {16'h0000, value[k]};
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= accept & i_avs_read;
			if (i_avs_read & ~busy_q)
				rdata_q <= rdata_d;
		end
	end

	// Datapath views; split words are joined here for the filter
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			gain0_q <= {accr_pkg::RST_CH0_GAIN_HI, 8'h00};
		else
		begin
			// Unsigned multiplier, 8000_00h is unity
			gain0_q[23:8] <= value[R_G0H];
			gain0_q[7:0] <= value[R_G0L][15:accr_pkg::LOWBYTE_LSB];
		end
	end

	// Sign sits in the high word; the low byte only extends precision
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			offs1_q <= 24'h000000;
		else
		begin
			offs1_q[23:8] <= value[R_O1H];
			offs1_q[7:0] <= value[R_O1L][15:accr_pkg::LOWBYTE_LSB];
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			gain1_q <= accr_pkg::RST_CH1_GAIN_HI;
		else
			gain1_q <= value[R_G1H];
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			phase_q <= 10'h000;
		else
			phase_q <= value[R_CFG][accr_pkg::PHASE_LSB +:
				accr_pkg::PHASE_W];
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			sel_q <= 2'h0;
		else
			sel_q <= value[R_CFG][accr_pkg::SEL_LSB +:
				accr_pkg::SEL_W];
	end

	accr_sel_decode u_sel (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_sel(value[R_CFG][accr_pkg::SEL_LSB +: accr_pkg::SEL_W]),
		.o_ext_connect(o_chan1_input_pair_connect),
		.o_short(o_chan1_inputs_shorted),
		.o_dc_diag(o_chan1_dc_diag),
		.o_ac_diag(o_chan1_ac_diag)
	);

	assign o_avs_waitrequest = ~busy_q & (i_avs_read | i_avs_write);
	assign o_avs_readdata = rdata_q;
	assign o_avs_readdatavalid = rvalid_q;
	assign o_chan0_gain = gain0_q;
	assign o_chan1_offset = offs1_q;
	assign o_chan1_gain_bits_high = gain1_q;
	assign o_chan1_phase_delay = phase_q;
	assign o_chan1_input_select = sel_q;
endmodule

// >>> logic/accr_pkg.sv
// Purpose: Constants for the channel calibration and configuration bank
// Assumes: Avalon-MM slave, 32-bit data, word addressing by index
// Notes: Register indices are kept as printed; byte address is index * 4
package accr_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam logic [ADDR_W-1:0] IDX_CH0_GAIN_HI = 5'h0c;
	localparam logic [ADDR_W-1:0] IDX_CH0_GAIN_LO = 5'h0d;
	localparam logic [ADDR_W-1:0] IDX_CH1_CONFIG = 5'h0e;
	localparam logic [ADDR_W-1:0] IDX_CH1_OFFS_HI = 5'h0f;
	localparam logic [ADDR_W-1:0] IDX_CH1_OFFS_LO = 5'h10;
	localparam logic [ADDR_W-1:0] IDX_CH1_GAIN_HI = 5'h11;
	localparam logic [REG_W-1:0] RST_CH0_GAIN_HI = 16'h8000;
	localparam logic [REG_W-1:0] RST_CH0_GAIN_LO = 16'h0000;
	localparam logic [REG_W-1:0] RST_CH1_CONFIG = 16'h0000;
	localparam logic [REG_W-1:0] RST_CH1_OFFS_HI = 16'h0000;
	localparam logic [REG_W-1:0] RST_CH1_OFFS_LO = 16'h0000;
	localparam logic [REG_W-1:0] RST_CH1_GAIN_HI = 16'h8000;
	// Writable masks; zero bits are reserved
	localparam logic [REG_W-1:0] MASK_FULL = 16'hffff;
	localparam logic [REG_W-1:0] MASK_LOW_BYTE = 16'hff00;
	localparam logic [REG_W-1:0] MASK_CONFIG = 16'hffc3;
	localparam int PHASE_LSB = 6;
	localparam int PHASE_W = 10;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 2;
	localparam int LOWBYTE_LSB = 8;
	typedef enum logic [1:0] {
		SEL_NORMAL = 2'h0,
		SEL_SHORTED = 2'h1,
		SEL_DC_DIAG = 2'h2,
		SEL_AC_DIAG = 2'h3
	} accr_sel_type;
endpackage

// >>> logic/accr_field_reg.sv
// Purpose: One 16-bit register with reserved bits held at zero
// Assumes: Byte enables from a 32-bit Avalon-MM word, low half used
// Notes: Reserved bits never store, so they read as zero
`timescale 1ns/10ps
module accr_field_reg #(
	parameter logic [15:0] RESET_VAL = 16'h0000,
	parameter logic [15:0] WMASK = 16'hffff
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_we,
	input wire logic [1:0] i_be,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_value
);
	logic [15:0] value_q;
	logic [15:0] lane_mask;

	assign lane_mask = {{8{i_be[1]}}, {8{i_be[0]}}} & WMASK;
	assign o_value = value_q;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			value_q <= RESET_VAL & WMASK;
		else if (i_we)
			value_q <= (value_q & ~lane_mask) | (i_wdata & lane_mask);
	end
endmodule

// >>> logic/accr_sel_decode.sv
// Purpose: Decode the channel-one input selection into switch controls
// Assumes: Selection comes from a register on the same clock
// Notes: Exactly one control is high at a time; registered outputs
`timescale 1ns/10ps
module accr_sel_decode (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [1:0] i_sel,
	output logic o_ext_connect,
	output logic o_short,
	output logic o_dc_diag,
	output logic o_ac_diag
);
	logic [3:0] onehot_d;
	logic [3:0] onehot_q;

	always_comb
	begin
		onehot_d = 4'h0;
		case (accr_pkg::accr_sel_type'(i_sel))
			accr_pkg::SEL_NORMAL: onehot_d = 4'h1;
			accr_pkg::SEL_SHORTED: onehot_d = 4'h2;
			accr_pkg::SEL_DC_DIAG: onehot_d = 4'h4;
			accr_pkg::SEL_AC_DIAG: onehot_d = 4'h8;
			default: onehot_d = 4'h1;
		endcase
	end

	// Reset to the normal path so the front end never floats
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			onehot_q <= 4'h1;
		else
			onehot_q <= onehot_d;
	end

	assign o_ext_connect = onehot_q[0];
	assign o_short = onehot_q[1];
	assign o_dc_diag = onehot_q[2];
	assign o_ac_diag = onehot_q[3];
endmodule

// >>> dv/accr_regs_sva.sv
// Purpose: Port assertions for the calibration bank
// Assumes: Master holds each request until waitrequest is low
// Notes: Datapath checks look two edges past the accept edge
`timescale 1ns/10ps
module accr_regs_sva (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [accr_pkg::ADDR_W+1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [accr_pkg::DATA_W-1:0] i_avs_writedata,
	input wire logic [accr_pkg::DATA_W-1:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic o_avs_readdatavalid,
	input wire logic [23:0] o_chan0_gain,
	input wire logic [23:0] o_chan1_offset,
	input wire logic [15:0] o_chan1_gain_bits_high,
	input wire logic [9:0] o_chan1_phase_delay,
	input wire logic [1:0] o_chan1_input_select,
	input wire logic o_chan1_input_pair_connect,
	input wire logic o_chan1_inputs_shorted,
	input wire logic o_chan1_dc_diag,
	input wire logic o_chan1_ac_diag
);
	logic acc;
	logic racc;
	logic [4:0] ix;
	logic [15:0] w;
	// Writes with both low byte lanes enabled only, so each check knows every stored bit
	assign acc = i_avs_write && !o_avs_waitrequest
		&& i_avs_byteenable[1:0] == 2'h3;
	assign racc = i_avs_read && !o_avs_waitrequest;
	assign ix = i_avs_address[6:2];
	assign w = i_avs_writedata[15:0];
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_g0lo;
		acc && ix == 5'h0d |=> ##1 o_chan0_gain[7:0] == $past(w[15:8], 2);
	endproperty
	a_g0lo: assert property (p_g0lo) else $error("gain0 low");
	property p_g0hi;
		acc && ix == 5'h0c |=> ##1 o_chan0_gain[23:8] == $past(w, 2);
	endproperty
	a_g0hi: assert property (p_g0hi) else $error("gain0 high");
	property p_phase;
		acc && ix == 5'h0e |=> ##1 o_chan1_phase_delay == $past(w[15:6], 2);
	endproperty
	a_phase: assert property (p_phase) else $error("phase");
	property p_sel;
		acc && ix == 5'h0e |=> ##1 o_chan1_input_select == $past(w[1:0], 2);
	endproperty
	a_sel: assert property (p_sel) else $error("select");
	property p_mux;
		{o_chan1_ac_diag, o_chan1_dc_diag, o_chan1_inputs_shorted,
			o_chan1_input_pair_connect} == 4'h1 << o_chan1_input_select;
	endproperty
	a_mux: assert property (p_mux) else $error("mux");
	property p_ofs;
		acc && ix == 5'h0f |=> ##1 o_chan1_offset[23:8] == $past(w, 2);
	endproperty
	a_ofs: assert property (p_ofs) else $error("offset");
	property p_ofslo;
		acc && ix == 5'h10 |=> ##1 o_chan1_offset[7:0] == $past(w[15:8], 2);
	endproperty
	a_ofslo: assert property (p_ofslo) else $error("offset low");
	property p_g1hi;
		acc && ix == 5'h11 |=> ##1 o_chan1_gain_bits_high == $past(w, 2);
	endproperty
	a_g1hi: assert property (p_g1hi) else $error("gain1");
	property p_rst;
		$fell(i_rst) |-> o_chan1_gain_bits_high == 16'h8000
			&& o_chan1_phase_delay == 10'h000 && o_chan1_input_select == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_resv;
		racc |-> o_avs_readdata[31:16] == 16'h0000
			&& (ix != 5'h0e || o_avs_readdata[5:2] == 4'h0)
			&& (ix != 5'h0d && ix != 5'h10 || o_avs_readdata[7:0] == 8'h00);
	endproperty
	a_resv: assert property (p_resv) else $error("reserved");
	c_wr: cover property (acc);
	c_rd: cover property (racc);
	c_ac: cover property (o_chan1_ac_diag);
endmodule
bind accr_regs accr_regs_sva u_sva (.*);

// >>> dv/tb_top.sv
// Purpose: Register-level bench for the calibration bank
// Assumes: Master waits on waitrequest, outputs lag a write by an edge
// Notes: Requests change just after a rising edge; outputs checked mid-cycle
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [6:0] adr = 7'h00;
	logic [3:0] be = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] q, rdat;
	logic wt, rdv;
	logic [23:0] g0, ofs;
	logic [15:0] g1;
	logic [9:0] ph;
	logic [1:0] sel;
	logic [3:0] mux;
	int mismatches = 0;
	int tests_run = 0;
	logic [15:0] val [6] = '{16'h1234, 16'habcd, 16'hffff, 16'h5a5a,
		16'hc3ff, 16'h7e81};
	logic [15:0] msk [6] = '{16'hffff, 16'hff00, 16'hffc3, 16'hffff,
		16'hff00, 16'hffff};
	logic [15:0] rsv [6] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h8000};
	always #5 clk = ~clk;
	accr_regs u_dut (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be),
		.i_avs_writedata(wd), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wt), .o_avs_readdatavalid(rdv),
		.o_chan0_gain(g0), .o_chan1_offset(ofs),
		.o_chan1_gain_bits_high(g1), .o_chan1_phase_delay(ph),
		.o_chan1_input_select(sel), .o_chan1_input_pair_connect(mux[0]),
		.o_chan1_inputs_shorted(mux[1]), .o_chan1_dc_diag(mux[2]),
		.o_chan1_ac_diag(mux[3]));
	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic results;
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Upper data lanes carry ones so that ignored bits get exercised
	task automatic acc(input logic w, input logic [4:0] ix,
		input logic [15:0] d, input logic [3:0] b);
		// Request stands until the edge that sees waitrequest low
		@(posedge clk);
		adr <= {ix, 2'h0};
		wd <= {16'hffff, d};
		be <= b;
		rd <= !w;
		wr <= w;
		do
			@(posedge clk);
		while (wt !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	initial
	begin
		#100000;
		mismatches++;
		results;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("gain0", g0, 32'h800000);
		chk("gain1", g1, 32'h8000);
		chk("mux", mux, 32'h1);
		for (int i = 0; i < 6; i++)
		begin
			acc(1'b0, 5'(12 + i), 16'h0, 4'hf);
			chk("reset", q, rsv[i]);
		end
		$display("test reset done");
		for (int i = 0; i < 6; i++)
		begin
			acc(1'b1, 5'(12 + i), val[i], 4'h3);
			acc(1'b0, 5'(12 + i), 16'h0, 4'hf);
			chk("readback", q, val[i] & msk[i]);
		end
		@(negedge clk);
		chk("gain0", g0, 32'h1234ab);
		chk("offset", ofs, 32'h5a5ac3);
		chk("gain1", g1, 32'h7e81);
		chk("phase", ph, 32'h3ff);
		$display("test fields done");
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b1, 5'h0e, {10'h201, 4'h0, 2'(i)}, 4'h3);
			// Switch controls follow the stored field one edge later
			@(posedge clk);
			@(negedge clk);
			chk("mux", mux, 32'h1 << i);
			chk("phase", ph, 32'h201);
		end
		$display("test select done");
		acc(1'b1, 5'h0f, 16'h0000, 4'h1);
		acc(1'b0, 5'h0f, 16'h0, 4'hf);
		chk("lanes", q, 32'h5a00);
		acc(1'b1, 5'h1f, 16'hffff, 4'h3);
		acc(1'b0, 5'h1f, 16'h0, 4'hf);
		chk("unmapped", q, 32'h0);
		$display("test lanes done");
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("gain1", g1, 32'h8000);
		chk("phase", ph, 32'h0);
		chk("mux", mux, 32'h1);
		acc(1'b0, 5'h0e, 16'h0, 4'hf);
		chk("reset", q, 32'h0);
		@(negedge clk);
		chk("rvalid", rdv, 32'h1);
		$display("test reset again done");
		results;
	end
endmodule
